// ---- cmst_pkg.sv ----
// constants and rule summary for the comparator global status register bank
// Summary of operation
// - idle-stop set halts all four comparators in idle; clear keeps them running
// - each event status bit copies bit 9 of its channel control register
// - each output status bit copies bit 8 of its channel control register
// - polarity 0: output reads 1 when positive input exceeds negative input
// - event status reads 1 after channel event, 0 while none occurred
// - unimplemented status bits read zero and ignore writes
package cmst_pkg;
	localparam int NCHAN = 4;
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_CHAN0 = 4'h1;
	localparam int IDLE_BIT = 15;
	localparam int EVT_LSB = 8;
	localparam int OUT_LSB = 0;
	localparam int CTL_EVT_BIT = 9;
	localparam int CTL_OUT_BIT = 8;
	localparam int CTL_POL_BIT = 4;
	localparam int CTL_EN_BIT = 15;
	localparam logic [15:0] STATUS_WMASK = 16'h8000;
	localparam logic [15:0] CTL_WMASK = 16'h8010;
	localparam logic [15:0] RESET_VALUE = 16'h0000;
endpackage

// ---- cmst_chan.sv ----
// one comparator channel: compare, polarity, event latch, control register
module cmst_chan (
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        run,
	input  wire logic        vin_gt,
	input  wire logic        wr,
	input  wire logic [15:0] wdata,
	output logic      [15:0] ctl
);
	logic        enable;
	logic        pol;
	logic        out_bit;
	logic        evt_bit;
	logic        active;
	logic        next_out;
	logic        evt_clear;
	assign active = enable && run;
	assign next_out = active ? (vin_gt ^ pol) : out_bit;
	assign evt_clear = wr && !wdata[cmst_pkg::CTL_EVT_BIT];
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			enable <= 1'b0;
			pol <= 1'b0;
			out_bit <= 1'b0;
			evt_bit <= 1'b0;
		end else begin
			if (wr) begin
				enable <= wdata[cmst_pkg::CTL_EN_BIT];
				pol <= wdata[cmst_pkg::CTL_POL_BIT];
			end
			out_bit <= next_out;
			// set wins over software clear
			if (active && (next_out != out_bit))
				evt_bit <= 1'b1;
			else if (evt_clear)
				evt_bit <= 1'b0;
		end
	end
	always_comb begin
		ctl = 16'h0000;
		ctl[cmst_pkg::CTL_EN_BIT] = enable;
		ctl[cmst_pkg::CTL_POL_BIT] = pol;
		ctl[cmst_pkg::CTL_EVT_BIT] = evt_bit;
		ctl[cmst_pkg::CTL_OUT_BIT] = out_bit;
	end
	a_evt_on_edge: assert property (@(posedge mclk) disable iff (!nrst)
		(active && (next_out != out_bit)) |=> evt_bit)
		else $error("event not latched on output change");
	a_out_polarity: assert property (@(posedge mclk) disable iff (!nrst)
		active |=> (out_bit == ($past(vin_gt) ^ $past(pol))))
		else $error("output does not follow input and polarity");
	a_out_frozen: assert property (@(posedge mclk) disable iff (!nrst)
		!active |=> $stable(out_bit))
		else $error("stopped comparator output changed");
endmodule

// ---- cmst_top.sv ----
// comparator global status register bank with four channels
//
// The implementer's own choices: the address map and strobed register access.
module cmst_top (
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	input  wire logic        idle_mode,
	input  wire logic [3:0]  vin_gt,
	output logic      [3:0]  comp_out
);
	logic              idle_stop_all;
	logic              run;
	logic [15:0]       ctl [cmst_pkg::NCHAN];
	logic [3:0]        evt_vec;
	logic [3:0]        out_vec;
	logic [15:0]       status;
	logic [15:0]       next_rdata;
	logic [15:0]       sel_ctl;
	logic              sel_ok;
	assign run = !(idle_stop_all && idle_mode);
	// one decoder serves both the write strobes and the read select
	function automatic logic chan_hit(input logic [3:0] a, input logic [1:0] idx);
		return a == (cmst_pkg::ADDR_CHAN0 + {2'b00, idx});
	endfunction
	genvar gi;
	generate
		for (gi = 0; gi < cmst_pkg::NCHAN; gi++) begin : g_ch
			logic wr_ch;
			assign wr_ch = wr && chan_hit(addr, 2'(gi));
			cmst_chan u_chan (
				.mclk   (mclk),
				.nrst   (nrst),
				.run    (run),
				.vin_gt (vin_gt[gi]),
				.wr     (wr_ch),
				.wdata  (wdata),
				.ctl    (ctl[gi])
			);
			assign evt_vec[gi] = ctl[gi][cmst_pkg::CTL_EVT_BIT];
			assign out_vec[gi] = ctl[gi][cmst_pkg::CTL_OUT_BIT];
		end
	endgenerate
	// only the idle-stop bit is stored; bits 11:8 and 3:0 mirror the channels, all other positions are constant zero
	assign status = {idle_stop_all, 3'h0, evt_vec, 4'h0, out_vec};
	assign sel_ok = chan_hit(addr, 2'd0) || chan_hit(addr, 2'd1) ||
		chan_hit(addr, 2'd2) || chan_hit(addr, 2'd3);
	assign sel_ctl = sel_ok ? ctl[2'(addr - cmst_pkg::ADDR_CHAN0)] : 16'h0000;
	assign next_rdata = (addr == cmst_pkg::ADDR_STATUS) ? status : sel_ctl;
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			idle_stop_all <= 1'b0;
			rdata <= cmst_pkg::RESET_VALUE;
			comp_out <= 4'h0;
		end else begin
			if (wr && addr == cmst_pkg::ADDR_STATUS)
				idle_stop_all <= wdata[cmst_pkg::IDLE_BIT];
			rdata <= rd ? next_rdata : 16'h0000;
			comp_out <= out_vec;
		end
	end
	a_status_copies: assert property (@(posedge mclk) disable iff (!nrst)
		(rd && addr == cmst_pkg::ADDR_STATUS) |=>
		(rdata[11:8] == $past(evt_vec) && rdata[3:0] == $past(out_vec)))
		else $error("status read does not mirror channel bits");
	a_reserved_zero: assert property (@(posedge mclk) disable iff (!nrst)
		(rd && addr == cmst_pkg::ADDR_STATUS) |=> ((rdata & 16'h70f0) == 16'h0000))
		else $error("reserved status bits not zero");
	a_idle_halts: assert property (@(posedge mclk) disable iff (!nrst)
		(idle_stop_all && idle_mode) |-> !run)
		else $error("comparators not stopped in idle");
	a_idle_runs: assert property (@(posedge mclk) disable iff (!nrst)
		!idle_stop_all |-> run)
		else $error("comparators halted without idle stop");
	a_out_mirror: assert property (@(posedge mclk) disable iff (!nrst)
		1'b1 |=> comp_out == $past(out_vec))
		else $error("output pins differ from status");

	a_rdata_idle: assert property (@(posedge mclk) disable iff (!nrst)
		!rd |=>
		(rdata == 16'h0000))
		else $error("read data not zero outside a read");

	a_unmapped_zero: assert property (@(posedge mclk) disable iff (!nrst)
		(rd && addr > 4'h4) |=>
		(rdata == 16'h0000))
		else $error("unmapped read not zero");

	a_status_write: assert property (@(posedge mclk) disable iff (!nrst)
		(wr && addr == cmst_pkg::ADDR_STATUS) |=>
		(idle_stop_all == $past(wdata[cmst_pkg::IDLE_BIT])))
		else $error("idle stop bit not written");

	a_status_hold: assert property (@(posedge mclk) disable iff (!nrst)
		!(wr && addr == cmst_pkg::ADDR_STATUS) |=>
		$stable(idle_stop_all))
		else $error("idle stop bit changed without status write");

	a_idle_stop_rd: assert property (@(posedge mclk) disable iff (!nrst)
		(rd && addr == cmst_pkg::ADDR_STATUS) |=>
		(rdata[cmst_pkg::IDLE_BIT] == $past(idle_stop_all)))
		else $error("idle stop bit not read back");

	a_idle_run_busy: assert property (@(posedge mclk) disable iff (!nrst)
		!idle_mode |->
		run)
		else $error("comparators halted outside idle");

	a_unmapped_wr: assert property (@(posedge mclk) disable iff (!nrst)
		(wr && addr > 4'h4) |=>
		$stable(idle_stop_all))
		else $error("unmapped write changed state");

	a_ch1_evt_copy: assert property (@(posedge mclk) disable iff (!nrst)
		(rd && addr == cmst_pkg::ADDR_STATUS) |=>
		(rdata[cmst_pkg::EVT_LSB] == $past(ctl[0][cmst_pkg::CTL_EVT_BIT])))
		else $error("channel 1 event status copy wrong");

	a_ch1_out_copy: assert property (@(posedge mclk) disable iff (!nrst)
		(rd && addr == cmst_pkg::ADDR_STATUS) |=>
		(rdata[cmst_pkg::OUT_LSB] == $past(ctl[0][cmst_pkg::CTL_OUT_BIT])))
		else $error("channel 1 output status copy wrong");

	a_ch1_ctl_read: assert property (@(posedge mclk) disable iff (!nrst)
		(rd && addr == 4'h1) |=>
		(rdata == $past(ctl[0])))
		else $error("channel 1 control read wrong");

	a_ch1_pol_zero: assert property (@(posedge mclk) disable iff (!nrst)
		(run && ctl[0][cmst_pkg::CTL_EN_BIT] && !ctl[0][cmst_pkg::CTL_POL_BIT]) |=>
		(ctl[0][cmst_pkg::CTL_OUT_BIT] == $past(vin_gt[0])))
		else $error("channel 1 output wrong with polarity 0");

	a_ch1_pol_one: assert property (@(posedge mclk) disable iff (!nrst)
		(run && ctl[0][cmst_pkg::CTL_EN_BIT] && ctl[0][cmst_pkg::CTL_POL_BIT]) |=>
		(ctl[0][cmst_pkg::CTL_OUT_BIT] == !$past(vin_gt[0])))
		else $error("channel 1 output wrong with polarity 1");

	a_ch1_evt_set: assert property (@(posedge mclk) disable iff (!nrst)
		(run && ctl[0][cmst_pkg::CTL_EN_BIT] && (ctl[0][cmst_pkg::CTL_OUT_BIT]
		!= (vin_gt[0] ^ ctl[0][cmst_pkg::CTL_POL_BIT]))) |=> ctl[0][cmst_pkg::CTL_EVT_BIT])
		else $error("channel 1 event not set");

	a_ch1_evt_quiet: assert property (@(posedge mclk) disable iff (!nrst)
		(!ctl[0][cmst_pkg::CTL_EVT_BIT] && !(run && ctl[0][cmst_pkg::CTL_EN_BIT])) |=>
		!ctl[0][cmst_pkg::CTL_EVT_BIT])
		else $error("channel 1 event set without activity");

	a_ch1_idle_hold: assert property (@(posedge mclk) disable iff (!nrst)
		!run |=>
		$stable(ctl[0][cmst_pkg::CTL_OUT_BIT]))
		else $error("channel 1 output moved while stopped");

	a_ch1_comp_pin: assert property (@(posedge mclk) disable iff (!nrst)
		1'b1 |=>
		(comp_out[0] == $past(ctl[0][cmst_pkg::CTL_OUT_BIT])))
		else $error("channel 1 output pin wrong");

	a_ch2_evt_copy: assert property (@(posedge mclk) disable iff (!nrst)
		(rd && addr == cmst_pkg::ADDR_STATUS) |=>
		(rdata[cmst_pkg::EVT_LSB + 1] == $past(ctl[1][cmst_pkg::CTL_EVT_BIT])))
		else $error("channel 2 event status copy wrong");

	a_ch2_out_copy: assert property (@(posedge mclk) disable iff (!nrst)
		(rd && addr == cmst_pkg::ADDR_STATUS) |=>
		(rdata[cmst_pkg::OUT_LSB + 1] == $past(ctl[1][cmst_pkg::CTL_OUT_BIT])))
		else $error("channel 2 output status copy wrong");

	a_ch2_ctl_read: assert property (@(posedge mclk) disable iff (!nrst)
		(rd && addr == 4'h2) |=>
		(rdata == $past(ctl[1])))
		else $error("channel 2 control read wrong");

	a_ch2_pol_zero: assert property (@(posedge mclk) disable iff (!nrst)
		(run && ctl[1][cmst_pkg::CTL_EN_BIT] && !ctl[1][cmst_pkg::CTL_POL_BIT]) |=>
		(ctl[1][cmst_pkg::CTL_OUT_BIT] == $past(vin_gt[1])))
		else $error("channel 2 output wrong with polarity 0");

	a_ch2_pol_one: assert property (@(posedge mclk) disable iff (!nrst)
		(run && ctl[1][cmst_pkg::CTL_EN_BIT] && ctl[1][cmst_pkg::CTL_POL_BIT]) |=>
		(ctl[1][cmst_pkg::CTL_OUT_BIT] == !$past(vin_gt[1])))
		else $error("channel 2 output wrong with polarity 1");

	a_ch2_evt_set: assert property (@(posedge mclk) disable iff (!nrst)
		(run && ctl[1][cmst_pkg::CTL_EN_BIT] && (ctl[1][cmst_pkg::CTL_OUT_BIT]
		!= (vin_gt[1] ^ ctl[1][cmst_pkg::CTL_POL_BIT]))) |=> ctl[1][cmst_pkg::CTL_EVT_BIT])
		else $error("channel 2 event not set");

	a_ch2_evt_quiet: assert property (@(posedge mclk) disable iff (!nrst)
		(!ctl[1][cmst_pkg::CTL_EVT_BIT] && !(run && ctl[1][cmst_pkg::CTL_EN_BIT])) |=>
		!ctl[1][cmst_pkg::CTL_EVT_BIT])
		else $error("channel 2 event set without activity");

	a_ch2_idle_hold: assert property (@(posedge mclk) disable iff (!nrst)
		!run |=>
		$stable(ctl[1][cmst_pkg::CTL_OUT_BIT]))
		else $error("channel 2 output moved while stopped");

	a_ch2_comp_pin: assert property (@(posedge mclk) disable iff (!nrst)
		1'b1 |=>
		(comp_out[1] == $past(ctl[1][cmst_pkg::CTL_OUT_BIT])))
		else $error("channel 2 output pin wrong");

	a_ch3_evt_copy: assert property (@(posedge mclk) disable iff (!nrst)
		(rd && addr == cmst_pkg::ADDR_STATUS) |=>
		(rdata[cmst_pkg::EVT_LSB + 2] == $past(ctl[2][cmst_pkg::CTL_EVT_BIT])))
		else $error("channel 3 event status copy wrong");

	a_ch3_out_copy: assert property (@(posedge mclk) disable iff (!nrst)
		(rd && addr == cmst_pkg::ADDR_STATUS) |=>
		(rdata[cmst_pkg::OUT_LSB + 2] == $past(ctl[2][cmst_pkg::CTL_OUT_BIT])))
		else $error("channel 3 output status copy wrong");

	a_ch3_ctl_read: assert property (@(posedge mclk) disable iff (!nrst)
		(rd && addr == 4'h3) |=>
		(rdata == $past(ctl[2])))
		else $error("channel 3 control read wrong");

	a_ch3_pol_zero: assert property (@(posedge mclk) disable iff (!nrst)
		(run && ctl[2][cmst_pkg::CTL_EN_BIT] && !ctl[2][cmst_pkg::CTL_POL_BIT]) |=>
		(ctl[2][cmst_pkg::CTL_OUT_BIT] == $past(vin_gt[2])))
		else $error("channel 3 output wrong with polarity 0");

	a_ch3_pol_one: assert property (@(posedge mclk) disable iff (!nrst)
		(run && ctl[2][cmst_pkg::CTL_EN_BIT] && ctl[2][cmst_pkg::CTL_POL_BIT]) |=>
		(ctl[2][cmst_pkg::CTL_OUT_BIT] == !$past(vin_gt[2])))
		else $error("channel 3 output wrong with polarity 1");

	a_ch3_evt_set: assert property (@(posedge mclk) disable iff (!nrst)
		(run && ctl[2][cmst_pkg::CTL_EN_BIT] && (ctl[2][cmst_pkg::CTL_OUT_BIT]
		!= (vin_gt[2] ^ ctl[2][cmst_pkg::CTL_POL_BIT]))) |=> ctl[2][cmst_pkg::CTL_EVT_BIT])
		else $error("channel 3 event not set");

	a_ch3_evt_quiet: assert property (@(posedge mclk) disable iff (!nrst)
		(!ctl[2][cmst_pkg::CTL_EVT_BIT] && !(run && ctl[2][cmst_pkg::CTL_EN_BIT])) |=>
		!ctl[2][cmst_pkg::CTL_EVT_BIT])
		else $error("channel 3 event set without activity");

	a_ch3_idle_hold: assert property (@(posedge mclk) disable iff (!nrst)
		!run |=>
		$stable(ctl[2][cmst_pkg::CTL_OUT_BIT]))
		else $error("channel 3 output moved while stopped");

	a_ch3_comp_pin: assert property (@(posedge mclk) disable iff (!nrst)
		1'b1 |=>
		(comp_out[2] == $past(ctl[2][cmst_pkg::CTL_OUT_BIT])))
		else $error("channel 3 output pin wrong");

	a_ch4_evt_copy: assert property (@(posedge mclk) disable iff (!nrst)
		(rd && addr == cmst_pkg::ADDR_STATUS) |=>
		(rdata[cmst_pkg::EVT_LSB + 3] == $past(ctl[3][cmst_pkg::CTL_EVT_BIT])))
		else $error("channel 4 event status copy wrong");

	a_ch4_out_copy: assert property (@(posedge mclk) disable iff (!nrst)
		(rd && addr == cmst_pkg::ADDR_STATUS) |=>
		(rdata[cmst_pkg::OUT_LSB + 3] == $past(ctl[3][cmst_pkg::CTL_OUT_BIT])))
		else $error("channel 4 output status copy wrong");

	a_ch4_ctl_read: assert property (@(posedge mclk) disable iff (!nrst)
		(rd && addr == 4'h4) |=>
		(rdata == $past(ctl[3])))
		else $error("channel 4 control read wrong");

	a_ch4_pol_zero: assert property (@(posedge mclk) disable iff (!nrst)
		(run && ctl[3][cmst_pkg::CTL_EN_BIT] && !ctl[3][cmst_pkg::CTL_POL_BIT]) |=>
		(ctl[3][cmst_pkg::CTL_OUT_BIT] == $past(vin_gt[3])))
		else $error("channel 4 output wrong with polarity 0");

	a_ch4_pol_one: assert property (@(posedge mclk) disable iff (!nrst)
		(run && ctl[3][cmst_pkg::CTL_EN_BIT] && ctl[3][cmst_pkg::CTL_POL_BIT]) |=>
		(ctl[3][cmst_pkg::CTL_OUT_BIT] == !$past(vin_gt[3])))
		else $error("channel 4 output wrong with polarity 1");

	a_ch4_evt_set: assert property (@(posedge mclk) disable iff (!nrst)
		(run && ctl[3][cmst_pkg::CTL_EN_BIT] && (ctl[3][cmst_pkg::CTL_OUT_BIT]
		!= (vin_gt[3] ^ ctl[3][cmst_pkg::CTL_POL_BIT]))) |=> ctl[3][cmst_pkg::CTL_EVT_BIT])
		else $error("channel 4 event not set");

	a_ch4_evt_quiet: assert property (@(posedge mclk) disable iff (!nrst)
		(!ctl[3][cmst_pkg::CTL_EVT_BIT] && !(run && ctl[3][cmst_pkg::CTL_EN_BIT])) |=>
		!ctl[3][cmst_pkg::CTL_EVT_BIT])
		else $error("channel 4 event set without activity");

	a_ch4_idle_hold: assert property (@(posedge mclk) disable iff (!nrst)
		!run |=>
		$stable(ctl[3][cmst_pkg::CTL_OUT_BIT]))
		else $error("channel 4 output moved while stopped");

	a_ch4_comp_pin: assert property (@(posedge mclk) disable iff (!nrst)
		1'b1 |=>
		(comp_out[3] == $past(ctl[3][cmst_pkg::CTL_OUT_BIT])))
		else $error("channel 4 output pin wrong");
endmodule

// ---- cmst_bench.sv ----
// self-checking bench for the comparator global status register bank
module cmst_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, idle_mode = 1'b0;
	logic [3:0]  addr = 4'h0, vin_gt = 4'h0, comp_out;
	logic [15:0] wdata = 16'h0000, rdata;
	int          n_fail = 0, n_compared = 0;
	cmst_top uut (.mclk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .idle_mode, .vin_gt, .comp_out);
	initial forever #20 mclk = ~mclk;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// a gap cycle after every strobe keeps each strobe assigned once per time step
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		chk(rdata, exp, "rdata");
	endtask
	task automatic wall(input logic [15:0] d);
		for (int i = 1; i <= 4; i++) wr_reg(4'(i), d);
		repeat (3) @(posedge mclk);
	endtask
	task automatic summarize;
		if (n_fail == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		#50000;
		n_fail++;
		summarize();
	end
	initial begin
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		rd_reg(4'h0, 16'h0000);
		wr_reg(4'h5, 16'hffff);
		rd_reg(4'h5, 16'h0000);
		wr_reg(4'h0, 16'hffff);
		rd_reg(4'h0, 16'h8000);
		@(posedge mclk);
		vin_gt <= 4'h5;
		wall(16'h8000);
		rd_reg(4'h0, 16'h8505);
		rd_reg(4'h1, 16'h8300);
		chk({12'h000, comp_out}, 16'h0005, "comp_out");
		wall(16'h8010);
		rd_reg(4'h0, 16'h8f0a);
		rd_reg(4'h2, 16'h8310);
		// rewriting with the event bit low clears it while outputs stay put
		wall(16'h8010);
		rd_reg(4'h0, 16'h800a);
		@(posedge mclk);
		idle_mode <= 1'b1;
		vin_gt <= 4'ha;
		repeat (3) @(posedge mclk);
		rd_reg(4'h0, 16'h800a);
		chk({12'h000, comp_out}, 16'h000a, "comp_out");
		wr_reg(4'h0, 16'h0000);
		repeat (3) @(posedge mclk);
		rd_reg(4'h0, 16'h0f05);
		summarize();
	end
endmodule
